// >>> core/cmpirq_pkg.sv
// Shared constants, types and layout helpers for the comparator interrupt bank
package cmpirq_pkg;
   // Largest comparator and window counts that the layout can hold
   localparam int NCMP_MAX = 8;
   localparam int NWIN_MAX = 4;
   localparam int ADDR_W = 8;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h10;
   localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h14;
   localparam logic [7:0] OFF_IRQ_ENABLE_VIEW = 8'h18;
   localparam logic [7:0] OFF_IRQ_PENDING_STATUS = 8'h1c;
   localparam logic [7:0] OFF_IRQ_PENDING_CLEAR = 8'h20;
   localparam logic [7:0] OFF_OUTPUT_OVERRIDE = 8'h24;
   localparam logic [7:0] OFF_IMPLEMENTED = 8'h30;
   // Field positions
   localparam int CTRL_OVERRIDE_SEL_POS = 7;
   localparam int IRQ_WIN_LSB = 24;
   localparam int STATUS_WIN_LSB = 24;
   localparam int IMPL_WIN_LSB = 16;
   localparam int IMPL_CMP_LSB = 0;
   // Reset values
   localparam logic [31:0] RST_ENABLE_VIEW = 32'h0000_0000;
   localparam logic [31:0] RST_PENDING = 32'h0000_0000;
   localparam logic [7:0] RST_OVERRIDE = 8'h00;
   localparam logic RST_OVERRIDE_SEL = 1'b0;
   // Comparator interrupt condition select
   typedef enum logic [1:0] {
      CMPIRQ_CMP_ABOVE, CMPIRQ_CMP_BELOW, CMPIRQ_CMP_TOGGLE, CMPIRQ_CMP_DONE
   } cmpirq_cmp_sel_t;
   // Window interrupt condition select
   typedef enum logic [2:0] {
      CMPIRQ_WIN_INSIDE, CMPIRQ_WIN_OUTSIDE, CMPIRQ_WIN_TOGGLE, CMPIRQ_WIN_DONE,
      CMPIRQ_WIN_ENTER, CMPIRQ_WIN_LEAVE, CMPIRQ_WIN_RSV6, CMPIRQ_WIN_RSV7
   } cmpirq_win_sel_t;
   // Bit positions shared by all interrupt registers
   function automatic int normal_pos(input int i);
      return 2 * i;
   endfunction
   function automatic int startup_pos(input int i);
      return 2 * i + 1;
   endfunction
   function automatic int window_pos(input int k);
      return IRQ_WIN_LSB + k;
   endfunction
endpackage

// >>> core/cmpirq_evt_if.sv
// Event and level bundle between the comparator and window detectors
`timescale 1ns/1ps
`default_nettype none
interface cmpirq_evt_if #(parameter int NCMP = 8, parameter int NWIN = 4);
   logic [NCMP-1:0] cmp_level;
   logic [NCMP-1:0] cmp_evt;
   logic [NWIN-1:0] win_inside;
   logic [NWIN-1:0] win_evt;
   modport cmp_src (output cmp_level, output cmp_evt);
   modport win_src (input cmp_level, output win_inside, output win_evt);
   modport sink (input cmp_level, input cmp_evt, input win_inside, input win_evt);
endinterface
`default_nettype wire

// >>> core/cmpirq_cmp_evt.sv
// Comparator output override and normal-mode event detection
`timescale 1ns/1ps
`default_nettype none
module cmpirq_cmp_evt #(parameter int NCMP = 8) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NCMP-1:0] raw,
   input wire logic [NCMP-1:0] ovr_val,
   input wire logic ovr_sel,
   input wire logic [NCMP-1:0] meas_done,
   input wire logic [2*NCMP-1:0] irq_sel,
   cmpirq_evt_if.cmp_src ev
);
   logic [NCMP-1:0] prev_r;
   logic seen_r;
   // Test override replaces every comparator output
   assign ev.cmp_level = ovr_sel ? ovr_val : raw;
   // Previous level for toggle detection; no toggle before first sample
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= '0;
         seen_r <= 1'b0;
      end else begin
         prev_r <= ev.cmp_level;
         seen_r <= 1'b1;
      end
   end
   // Condition selected per comparator
   always_comb begin
      for (int i = 0; i < NCMP; i++) begin
         unique case (cmpirq_pkg::cmpirq_cmp_sel_t'(irq_sel[2*i +: 2]))
            cmpirq_pkg::CMPIRQ_CMP_ABOVE: ev.cmp_evt[i] = ev.cmp_level[i];
            cmpirq_pkg::CMPIRQ_CMP_BELOW: ev.cmp_evt[i] = ~ev.cmp_level[i];
            cmpirq_pkg::CMPIRQ_CMP_TOGGLE: ev.cmp_evt[i] = seen_r & (prev_r[i] ^ ev.cmp_level[i]);
            cmpirq_pkg::CMPIRQ_CMP_DONE: ev.cmp_evt[i] = meas_done[i];
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> core/cmpirq_win_evt.sv
// Window pair inside status and window event detection
`timescale 1ns/1ps
`default_nettype none
module cmpirq_win_evt #(parameter int NWIN = 4) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NWIN-1:0] win_en,
   input wire logic [2*NWIN-1:0] meas_done,
   input wire logic [3*NWIN-1:0] irq_sel,
   cmpirq_evt_if.win_src ev
);
   logic [NWIN-1:0] prev_r;
   logic seen_r;
   // Inside: above lower (even) comparator and below upper (odd) one
   always_comb begin
      for (int k = 0; k < NWIN; k++) begin
         ev.win_inside[k] = ev.cmp_level[2*k] & ~ev.cmp_level[2*k+1];
      end
   end
   // Previous inside state for edge conditions
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= '0;
         seen_r <= 1'b0;
      end else begin
         prev_r <= ev.win_inside;
         seen_r <= 1'b1;
      end
   end
   // Condition selected per window, only while window mode is on
   always_comb begin
      for (int k = 0; k < NWIN; k++) begin
         unique case (cmpirq_pkg::cmpirq_win_sel_t'(irq_sel[3*k +: 3]))
            cmpirq_pkg::CMPIRQ_WIN_INSIDE: ev.win_evt[k] = ev.win_inside[k];
            cmpirq_pkg::CMPIRQ_WIN_OUTSIDE: ev.win_evt[k] = ~ev.win_inside[k];
            cmpirq_pkg::CMPIRQ_WIN_TOGGLE: ev.win_evt[k] = seen_r & (prev_r[k] ^ ev.win_inside[k]);
            cmpirq_pkg::CMPIRQ_WIN_DONE: ev.win_evt[k] = |meas_done[2*k +: 2];
            cmpirq_pkg::CMPIRQ_WIN_ENTER: ev.win_evt[k] = seen_r & ~prev_r[k] & ev.win_inside[k];
            cmpirq_pkg::CMPIRQ_WIN_LEAVE: ev.win_evt[k] = seen_r & prev_r[k] & ~ev.win_inside[k];
            default: ev.win_evt[k] = 1'b0;
         endcase
         ev.win_evt[k] = ev.win_evt[k] & win_en[k];
      end
   end
endmodule
`default_nettype wire

// >>> core/cmpirq_top.sv
// Interrupt, status, test and feature registers of the comparator interface
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cmpirq_top #(
   parameter int NCMP = 8,
   parameter int NWIN = 4
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [cmpirq_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [NCMP-1:0] CMP_OUT,
   input wire logic [NCMP-1:0] CMP_STARTUP_DONE,
   input wire logic [NCMP-1:0] CMP_MEAS_DONE,
   input wire logic [2*NCMP-1:0] CMP_IRQ_SEL,
   input wire logic [NWIN-1:0] WIN_ENABLE,
   input wire logic [3*NWIN-1:0] WIN_IRQ_SEL,
   output logic [NCMP-1:0] CMP_RESULT,
   output logic IRQ
);

   // Elaboration checks of the counts the layout can serve
   initial begin
      if (NCMP < 1 || NCMP > cmpirq_pkg::NCMP_MAX) begin
         $error("cmpirq_top: comparator count out of range");
      end
      if (NWIN < 0 || NWIN > cmpirq_pkg::NWIN_MAX) begin
         $error("cmpirq_top: window count out of range");
      end
      // Each window needs its own lower and upper comparator
      if (2 * NWIN > NCMP) begin
         $error("cmpirq_top: too few comparators for the windows");
      end
   end

   // Bits of the interrupt layout that exist in this build
   function automatic logic [31:0] irq_layout();
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < NCMP; i++) begin
         m[cmpirq_pkg::normal_pos(i)] = 1'b1;
         m[cmpirq_pkg::startup_pos(i)] = 1'b1;
      end
      for (int k = 0; k < NWIN; k++) begin
         m[cmpirq_pkg::window_pos(k)] = 1'b1;
      end
      return m;
   endfunction

   // Spread per-source event vectors into the shared layout
   function automatic logic [31:0] irq_pack(
      input logic [NCMP-1:0] norm,
      input logic [NCMP-1:0] sut,
      input logic [NWIN-1:0] win
   );
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < NCMP; i++) begin
         v[cmpirq_pkg::normal_pos(i)] = norm[i];
         v[cmpirq_pkg::startup_pos(i)] = sut[i];
      end
      for (int k = 0; k < NWIN; k++) begin
         v[cmpirq_pkg::window_pos(k)] = win[k];
      end
      return v;
   endfunction

   // Fixed feature flags for this build
   function automatic logic [31:0] impl_value();
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < NCMP; i++) begin
         v[cmpirq_pkg::IMPL_CMP_LSB + i] = 1'b1;
      end
      for (int k = 0; k < NWIN; k++) begin
         v[cmpirq_pkg::IMPL_WIN_LSB + k] = 1'b1;
      end
      return v;
   endfunction

   localparam logic [31:0] IRQ_MASK = irq_layout();
   localparam logic [31:0] IMPL_VAL = impl_value();

   // Interrupt mask and pending state
   logic [31:0] enable_view_r;
   logic [31:0] enable_view_nxt;
   logic [31:0] pending_r;
   logic [31:0] pending_nxt;

   // Test override state
   logic [7:0] override_r;
   logic override_sel_r;

   // Bus answer and output registers
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [NCMP-1:0] result_r;
   logic irq_r;
   logic irq_nxt;

   // Bus phase qualifiers
   logic acc_start;
   logic acc_done;
   logic wr_done;
   logic mapped;
   logic [31:0] wdata_irq;
   logic [31:0] read_val;
   logic [31:0] status_val;
   logic [NCMP-1:0] ovr_bits;

   // Ones written to the set and clear registers
   logic [31:0] en_set;
   logic [31:0] en_clr;
   logic [31:0] pend_clr;

   // Events per source and packed into the shared layout
   logic [NCMP-1:0] norm_evt;
   logic [NCMP-1:0] sut_evt;
   logic [NWIN-1:0] win_evt;
   logic [2*NWIN-1:0] win_meas_done;
   logic [31:0] event_vec;

   // Write completing at the given offset in this cycle
   function automatic logic wr_hit(input logic [cmpirq_pkg::ADDR_W-1:0] off);
      return wr_done && (PADDR == off);
   endfunction

   // Levels and events shared by the two detectors
   cmpirq_evt_if #(.NCMP(NCMP), .NWIN(NWIN)) evt ();

   // Override bits for the comparators present
   assign ovr_bits = override_r[NCMP-1:0];

   // Comparator override and normal-mode conditions
   cmpirq_cmp_evt #(.NCMP(NCMP)) u_cmp (
      .clk(REF_CLK),
      .rst(RESET),
      .raw(CMP_OUT),
      .ovr_val(ovr_bits),
      .ovr_sel(override_sel_r),
      .meas_done(CMP_MEAS_DONE),
      .irq_sel(CMP_IRQ_SEL),
      .ev(evt.cmp_src)
   );

   // Window pairs share the done pulses of their two comparators
   assign win_meas_done = CMP_MEAS_DONE[2*NWIN-1:0];

   // Window conditions built from comparator pairs
   cmpirq_win_evt #(.NWIN(NWIN)) u_win (
      .clk(REF_CLK),
      .rst(RESET),
      .win_en(WIN_ENABLE),
      .meas_done(win_meas_done),
      .irq_sel(WIN_IRQ_SEL),
      .ev(evt.win_src)
   );

   // Access phase: first cycle computes the answer, second completes it
   assign acc_start = PSEL & PENABLE & ~pready_r;
   assign acc_done = PSEL & PENABLE & pready_r;
   assign wr_done = acc_done & PWRITE;
   assign wdata_irq = PWDATA & IRQ_MASK;

   // Known addresses; anything else answers with an error
   always_comb begin
      unique case (PADDR)
         cmpirq_pkg::OFF_CTRL,
         cmpirq_pkg::OFF_STATUS,
         cmpirq_pkg::OFF_IRQ_ENABLE_SET,
         cmpirq_pkg::OFF_IRQ_ENABLE_CLEAR,
         cmpirq_pkg::OFF_IRQ_ENABLE_VIEW,
         cmpirq_pkg::OFF_IRQ_PENDING_STATUS,
         cmpirq_pkg::OFF_IRQ_PENDING_CLEAR,
         cmpirq_pkg::OFF_OUTPUT_OVERRIDE,
         cmpirq_pkg::OFF_IMPLEMENTED: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Live status: comparator results on even bits, window inside on top
   always_comb begin
      status_val = '0;
      for (int i = 0; i < NCMP; i++) begin
         status_val[cmpirq_pkg::normal_pos(i)] = evt.cmp_level[i];
      end
      for (int k = 0; k < NWIN; k++) begin
         status_val[cmpirq_pkg::STATUS_WIN_LSB + k] = evt.win_inside[k];
      end
   end

   // Read multiplexer; write-only registers read as zero
   always_comb begin
      read_val = '0;
      unique case (PADDR)
         cmpirq_pkg::OFF_CTRL: read_val[cmpirq_pkg::CTRL_OVERRIDE_SEL_POS] = override_sel_r;
         cmpirq_pkg::OFF_STATUS: read_val = status_val;
         cmpirq_pkg::OFF_IRQ_ENABLE_VIEW: read_val = enable_view_r;
         cmpirq_pkg::OFF_IRQ_PENDING_STATUS: read_val = pending_r;
         cmpirq_pkg::OFF_OUTPUT_OVERRIDE: read_val[7:0] = override_r;
         cmpirq_pkg::OFF_IMPLEMENTED: read_val = IMPL_VAL;
         default: read_val = '0;
      endcase
   end

   // Bus answer: ready one cycle into the access phase
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= acc_start;
         pslverr_r <= acc_start & ~mapped; // unmapped answers with an error
      end
   end

   // Read data stands only in the answer cycle, zero otherwise
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         prdata_r <= '0;
      end else if (acc_start && !PWRITE) begin
         prdata_r <= read_val;
      end else if (acc_done) begin
         prdata_r <= '0;
      end
   end

   // Ones written to the enable set and clear registers, existing bits only
   always_comb begin
      en_set = '0;
      en_clr = '0;
      if (wr_hit(cmpirq_pkg::OFF_IRQ_ENABLE_SET)) begin
         en_set = wdata_irq;
      end
      if (wr_hit(cmpirq_pkg::OFF_IRQ_ENABLE_CLEAR)) begin
         en_clr = wdata_irq;
      end
   end

   // Mask: set by enable-set ones, cleared by enable-clear ones
   assign enable_view_nxt = (enable_view_r | en_set) & ~en_clr;

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         enable_view_r <= cmpirq_pkg::RST_ENABLE_VIEW;
      end else begin
         enable_view_r <= enable_view_nxt;
      end
   end

   // Events of each source kind
   assign norm_evt = evt.cmp_evt;
   assign sut_evt = CMP_STARTUP_DONE;
   assign win_evt = evt.win_evt;
   // Events gathered into the shared layout
   assign event_vec = irq_pack(norm_evt, sut_evt, win_evt);

   // Ones written to the pending clear register
   always_comb begin
      pend_clr = '0;
      if (wr_hit(cmpirq_pkg::OFF_IRQ_PENDING_CLEAR)) begin
         pend_clr = wdata_irq;
      end
   end

   // Pending: sticky, cleared by ones, a same-cycle event wins
   assign pending_nxt = (pending_r & ~pend_clr) | event_vec;

   // Bits with no source in this build stay low
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         pending_r <= cmpirq_pkg::RST_PENDING;
      end else begin
         pending_r <= pending_nxt & IRQ_MASK;
      end
   end

   // Test override values
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         override_r <= cmpirq_pkg::RST_OVERRIDE;
      end else if (wr_hit(cmpirq_pkg::OFF_OUTPUT_OVERRIDE)) begin
         override_r <= PWDATA[7:0];
      end
   end

   // Global override select
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         override_sel_r <= cmpirq_pkg::RST_OVERRIDE_SEL;
      end else if (wr_hit(cmpirq_pkg::OFF_CTRL)) begin
         override_sel_r <= PWDATA[cmpirq_pkg::CTRL_OVERRIDE_SEL_POS];
      end
   end

   // Registered comparator result as seen by the logic
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         result_r <= '0;
      end else begin
         result_r <= evt.cmp_level;
      end
   end

   // Next level from next pending and mask state
   // so a clear drops the line on the edge where it lands
   assign irq_nxt = |(pending_nxt & enable_view_nxt & IRQ_MASK);

   // Interrupt line registered from its next value
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign CMP_RESULT = result_r;
   assign IRQ = irq_r;

endmodule
`default_nettype wire

// >>> tb/cmpirq_cmp_bank.sv
// Behavioural comparator bank facing the interrupt bank
`timescale 1ns/1ps
`default_nettype none
module cmpirq_cmp_bank #(parameter int N = 8, parameter int SU = 200) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [N-1:0] above,
   input wire logic meas,
   output logic [N-1:0] out,
   output logic [N-1:0] su_done,
   output logic [N-1:0] m_done
);
   int cnt;
   // Startup timer after reset
   always_ff @(posedge clk) begin
      if (rst) cnt <= 0;
      else if (cnt < SU + N) cnt <= cnt + 1;
   end
   // One staggered startup pulse per comparator
   always_comb begin
      for (int i = 0; i < N; i++) su_done[i] = !rst && (cnt == SU + i);
   end
   // Output high while plus input is above minus; done a cycle after request
   always_ff @(posedge clk) begin
      out <= above;
      m_done <= rst ? '0 : {N{meas}};
   end
endmodule
`default_nettype wire

// >>> tb/cmpirq_top_monitor.sv
// Port checker for the comparator interrupt bank
`timescale 1ns/1ps
`default_nettype none
module cmpirq_top_monitor #(parameter int NCMP = 8, parameter int NWIN = 4) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [cmpirq_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [NCMP-1:0] CMP_OUT,
   input wire logic [NCMP-1:0] CMP_RESULT,
   input wire logic IRQ
);
   localparam logic [31:0] FEAT = (((32'h1 << NWIN) - 32'h1) << 16) | ((32'h1 << NCMP) - 32'h1);
   logic acc, wr_done, mapped, wo, clr, sel_r;
   logic [NCMP-1:0] ovr_r, eff;
   // Bus phase decode
   assign acc = PSEL && PENABLE && !PREADY;
   assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
   assign mapped = PADDR inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
   assign wo = PADDR inside {8'h10, 8'h14, 8'h20};
   assign clr = PADDR inside {8'h14, 8'h20};
   assign eff = sel_r ? ovr_r : CMP_OUT;
   // Shadow of override select and values
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         sel_r <= 1'b0;
         ovr_r <= '0;
      end else if (wr_done && PADDR == cmpirq_pkg::OFF_CTRL) begin
         sel_r <= PWDATA[cmpirq_pkg::CTRL_OVERRIDE_SEL_POS];
      end else if (wr_done && PADDR == cmpirq_pkg::OFF_OUTPUT_OVERRIDE) begin
         ovr_r <= PWDATA[NCMP-1:0];
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   property p_answer; acc |=> PREADY && PSEL && PENABLE; endproperty
   a_answer: assert property (p_answer) else $error("ready late");
   property p_rdy_pulse; PREADY |=> !PREADY; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_idle_data; !PREADY |-> PRDATA == 32'h0 && !PSLVERR; endproperty
   a_idle_data: assert property (p_idle_data) else $error("data outside answer");
   property p_unmapped; acc && !mapped |=> PSLVERR && PRDATA == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
   property p_feat; acc && !PWRITE && PADDR == 8'h30 |=> PRDATA == FEAT && !PSLVERR; endproperty
   a_feat: assert property (p_feat) else $error("feature word wrong");
   property p_wo_read; acc && !PWRITE && wo |=> PRDATA == 32'h0 && !PSLVERR; endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only read");
   property p_irq_fall; $fell(IRQ) |-> $past(wr_done) && $past(clr); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
   property p_disable_all; wr_done && PADDR == 8'h14 && PWDATA == 32'hffffffff |=> !IRQ;
   endproperty
   a_disable_all: assert property (p_disable_all) else $error("irq while masked");
   property p_result; !$past(RESET) |-> CMP_RESULT == $past(eff); endproperty
   a_result: assert property (p_result) else $error("result wrong");
endmodule
`default_nettype wire

// >>> tb/cmpirq_top_tb.sv
// Self-checking bench for the comparator interrupt bank
`timescale 1ns/1ps
`default_nettype none
module cmpirq_top_tb;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, meas = 1'b0;
   logic [7:0] addr = '0, above = '0, cout, csu, cmd, cres;
   logic [31:0] wdata = '0, prdata, r, d;
   logic [15:0] isel = '1;
   logic [3:0] wen = '0;
   logic [11:0] wsel = '0;
   logic pready, pslverr, irq;
   logic [32:0] e;
   logic [32:0] expq[$];
   logic [7:0] zr[7] = '{8'h18, 8'h1c, 8'h24, 8'h00, 8'h10, 8'h14, 8'h20};
   logic [3:0] wx[6] = '{4'h3, 4'hf, 4'h3, 4'hf, 4'h2, 4'h1};
   int n_fail = 0, n_compared = 0, seed = 58633;
   always #10 clk = ~clk;
   cmpirq_cmp_bank cmpirq_cmp_bank_inst (.clk(clk), .rst(rst), .above(above), .meas(meas),
      .out(cout), .su_done(csu), .m_done(cmd));
   cmpirq_top cmpirq_top_inst (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(addr), .PWDATA(wdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CMP_OUT(cout), .CMP_STARTUP_DONE(csu), .CMP_MEAS_DONE(cmd),
      .CMP_IRQ_SEL(isel), .WIN_ENABLE(wen), .WIN_IRQ_SEL(wsel), .CMP_RESULT(cres), .IRQ(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One bus transfer; the expected answer is noted first
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
      input logic [32:0] x);
      expq.push_back(x);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, {1'b0, x});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 33'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   function automatic logic [31:0] ev(input logic [7:0] x);
      ev = '0;
      for (int i = 0; i < 8; i++) ev[2*i] = x[i];
   endfunction
   // Expected live status: results on even bits, window inside on top
   function automatic logic [31:0] st(input logic [7:0] x);
      st = ev(x);
      for (int k = 0; k < 4; k++) st[24+k] = x[2*k] & ~x[2*k+1];
   endfunction
   task automatic tally_and_finish();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Answer watcher: oldest note against each completed transfer
   always @(posedge clk) begin
      if (pready === 1'b1 && expq.size() > 0) begin
         e = expq.pop_front();
         chk({31'h0, pslverr}, {31'h0, e[32]});
         chk(prdata, e[31:0]);
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int j = 0; j < 7; j++) rd(zr[j], 32'h0);
      rd(8'h30, 32'h000f_00ff);
      apb(1'b0, 8'h08, 32'h0, {1'b1, 32'h0});
      wr(8'h18, 32'hffff_ffff);
      rd(8'h18, 32'h0);
      r = $random(seed) & 32'h0f00_ffff;
      wr(8'h10, r);
      wr(8'h10, 32'h0);
      rd(8'h18, r);
      d = $random(seed);
      wr(8'h14, d);
      wr(8'h10, 32'hf0ff_0000);
      rd(8'h18, r & ~d);
      // Startup flags: sticky, masked, cleared
      wr(8'h14, 32'hffff_ffff);
      cyc(200);
      rd(8'h1c, 32'h0000_aaaa);
      chk({31'h0, irq}, 32'h0);
      wr(8'h10, 32'h2);
      cyc(1);
      chk({31'h0, irq}, 32'h1);
      wr(8'h20, 32'h2);
      cyc(1);
      chk({31'h0, irq}, 32'h0);
      rd(8'h1c, 32'h0000_aaa8);
      // Every comparator condition select
      for (int c = 0; c < 4; c++) begin
         r = $random(seed);
         d = $random(seed);
         isel <= '1;
         above <= r[7:0];
         cyc(4);
         wr(8'h20, 32'hffff_ffff);
         isel <= {8{2'(c)}};
         cyc(3);
         above <= d[7:0];
         meas <= 1'b1;
         cyc(1);
         meas <= 1'b0;
         cyc(4);
         isel <= '1;
         cyc(2);
         rd(8'h1c, ev(c == 0 ? r[7:0] | d[7:0] : c == 1 ? ~(r[7:0] & d[7:0]) :
            c == 2 ? r[7:0] ^ d[7:0] : 8'hff));
      end
      // Window conditions across a level change with a done pulse
      for (int w = 0; w < 6; w++) begin
         above <= 8'h01;
         cyc(3);
         wr(8'h20, 32'hffff_ffff);
         wsel <= {4{3'(w)}};
         wen <= 4'hf;
         cyc(2);
         above <= 8'h04;
         meas <= 1'b1;
         cyc(1);
         meas <= 1'b0;
         cyc(4);
         wen <= 4'h0;
         cyc(2);
         rd(8'h1c, {4'h0, wx[w], 24'h00_5555});
      end
      // Override values and global select
      r = $random(seed);
      wr(8'h24, r);
      rd(8'h24, {24'h0, r[7:0]});
      above <= ~r[7:0];
      wr(8'h00, 32'h80);
      cyc(3);
      chk({24'h0, cres}, {24'h0, r[7:0]});
      rd(8'h04, st(r[7:0]));
      wr(8'h00, 32'h0);
      cyc(3);
      chk({24'h0, cres}, {24'h0, ~r[7:0]});
      rd(8'h04, st(~r[7:0]));
      tally_and_finish();
   end
   // Watchdog
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
endmodule
bind cmpirq_top cmpirq_top_monitor #(.NCMP(NCMP), .NWIN(NWIN)) cmpirq_top_monitor_inst (
   .REF_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
   .PSLVERR, .CMP_OUT, .CMP_RESULT, .IRQ);
`default_nettype wire
